// file: shared/pwr_state_pkg.sv
// Constants and state types for the board power state controller.
// Assumes a 125 MHz standby clock that runs whenever AC power is present.
package pwr_state_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned LONG_PRESS_S = 4;
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  // Sleep type codes carried on the sleep command
  localparam logic [1:0] SLP_S1 = 2'h0;
  localparam logic [1:0] SLP_S3 = 2'h1;
  localparam logic [1:0] SLP_S4 = 2'h2;
  localparam logic [1:0] SLP_S5 = 2'h3;
  typedef enum logic [4:0] {
    ST_S0 = 5'h01,
    ST_S1 = 5'h02,
    ST_S3 = 5'h04,
    ST_S4 = 5'h08,
    ST_S5 = 5'h10
  } pwr_state_t;
endpackage

// file: rtl/board_power_state_controller.sv
// Board power state controller: state, switch timing, wake gating, rails.
// Assumes standby-powered clock; the switch and the seven wake pin inputs are asynchronous.
`timescale 1ns/10ps
module board_power_state_controller #(
  parameter int unsigned LONG_PRESS_CYC = pwr_state_pkg::LONG_PRESS_CYC,
  parameter int unsigned DEBOUNCE_CYC = pwr_state_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwr_sw_n_i,
  input wire logic rtc_alarm_i,
  input wire logic pcie_wake_n_i,
  input wire logic ring_i,
  input wire logic kbd_act_i,
  input wire logic usb_act_i,
  input wire logic lan_wake_i,
  input wire logic pme_n_i,
  input wire logic lan_pme_s5_en_i,
  input wire logic sleep_req_i,
  input wire logic [1:0] sleep_type_i,
  input wire logic restore_en_i,
  input wire logic last_on_i,
  output logic fan_on_o,
  output logic main_rails_on_o,
  output logic cpu_pwr_on_o,
  output logic cold_boot_o,
  output logic resume_o,
  output logic [4:0] state_o
);
  // Two-flop synchronisers for the switch and the seven wake inputs
  localparam int NIN = 8;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_ff;
  logic [NIN-1:0] s2_ff;
  assign raw = {~pwr_sw_n_i, rtc_alarm_i, ~pcie_wake_n_i, ring_i,
                kbd_act_i, usb_act_i, lan_wake_i, ~pme_n_i};
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= raw[g];
          s2_ff[g] <= s1_ff[g];
        end
      end
    end
  endgenerate

  logic sw_raw, alarm, pwake, ring, kbd, usb, lan, pme;
  assign {sw_raw, alarm, pwake, ring, kbd, usb, lan, pme} = s2_ff;

  // Debounce the switch
  logic sw_db_ff;
  logic [31:0] db_cnt_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_db_ff <= 1'b0;
      db_cnt_ff <= 32'h0;
    end else if (sw_raw == sw_db_ff) begin
      db_cnt_ff <= 32'h0;
    end else if (db_cnt_ff >= DEBOUNCE_CYC - 1) begin
      sw_db_ff <= sw_raw;
      db_cnt_ff <= 32'h0;
    end else begin
      db_cnt_ff <= db_cnt_ff + 32'h1;
    end
  end

  // Press timer from debounced edge; long fires once at exactly the limit
  logic [31:0] press_cnt_ff;
  logic long_done_ff;
  logic sw_prev_ff;
  logic press_rise, press_fall, long_hit, short_press;
  assign press_rise = sw_db_ff & ~sw_prev_ff;
  assign press_fall = ~sw_db_ff & sw_prev_ff;
  assign long_hit = sw_db_ff & ~long_done_ff & (press_cnt_ff >= LONG_PRESS_CYC - 1);
  assign short_press = press_fall & ~long_done_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_prev_ff <= 1'b0;
      press_cnt_ff <= 32'h0;
      long_done_ff <= 1'b0;
    end else begin
      sw_prev_ff <= sw_db_ff;
      if (press_rise) begin
        press_cnt_ff <= 32'h0;
        long_done_ff <= 1'b0;
      end else if (sw_db_ff && !long_done_ff) begin
        press_cnt_ff <= press_cnt_ff + 32'h1;
        if (long_hit) begin
          long_done_ff <= 1'b1;
        end
      end
    end
  end

  pwr_state_pkg::pwr_state_t state_ff;
  pwr_state_pkg::pwr_state_t nxt_state;

  // Wake gating by current sleep state; events are levels seen only now
  function automatic logic wake_ok(input pwr_state_pkg::pwr_state_t st, input logic any_sleep,
                                   input logic s13, input logic s134, input logic s5x);
    case (st)
      pwr_state_pkg::ST_S1, pwr_state_pkg::ST_S3: wake_ok = any_sleep | s13 | s134;
      pwr_state_pkg::ST_S4: wake_ok = any_sleep | s134;
      pwr_state_pkg::ST_S5: wake_ok = any_sleep | s5x;
      default: wake_ok = 1'b0;
    endcase
  endfunction

  logic wake_any, wake_lanpme, wake_legacy, wake;
  assign wake_any = alarm | pwake;
  assign wake_legacy = ring | kbd | usb;
  assign wake_lanpme = lan | pme;
  // Not latched: a disallowed event leaves no trace
  assign wake = wake_ok(state_ff, wake_any, wake_legacy, wake_lanpme,
                        wake_lanpme & lan_pme_s5_en_i);

  // Power-on restore sampled after reset release
  logic boot_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pwr_state_pkg::ST_S0: begin
        if (long_hit) begin
          nxt_state = pwr_state_pkg::ST_S5;
        end else if (short_press) begin
          nxt_state = pwr_state_pkg::ST_S1;
        end else if (sleep_req_i) begin
          case (sleep_type_i)
            pwr_state_pkg::SLP_S1: nxt_state = pwr_state_pkg::ST_S1;
            pwr_state_pkg::SLP_S3: nxt_state = pwr_state_pkg::ST_S3;
            pwr_state_pkg::SLP_S4: nxt_state = pwr_state_pkg::ST_S4;
            default: nxt_state = pwr_state_pkg::ST_S5;
          endcase
        end
      end
      pwr_state_pkg::ST_S1, pwr_state_pkg::ST_S3, pwr_state_pkg::ST_S4: begin
        if (long_hit) begin
          nxt_state = pwr_state_pkg::ST_S5;
        end else if (short_press || wake) begin
          nxt_state = pwr_state_pkg::ST_S0;
        end
      end
      pwr_state_pkg::ST_S5: begin
        if (boot_ff) begin
          if (restore_en_i && last_on_i) begin
            nxt_state = pwr_state_pkg::ST_S0;
          end
        end else if (short_press || wake) begin
          nxt_state = pwr_state_pkg::ST_S0;
        end
      end
      default: nxt_state = pwr_state_pkg::ST_S5;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= pwr_state_pkg::ST_S5;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs registered from next state
  logic fan_ff, rails_ff, cpu_ff, cold_ff, resume_ff;
  logic in_sleep;
  assign in_sleep = (state_ff == pwr_state_pkg::ST_S1) || (state_ff == pwr_state_pkg::ST_S3) ||
                    (state_ff == pwr_state_pkg::ST_S4);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fan_ff <= 1'b0;
      rails_ff <= 1'b0;
      cpu_ff <= 1'b0;
      cold_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      fan_ff <= (nxt_state == pwr_state_pkg::ST_S0) || (nxt_state == pwr_state_pkg::ST_S1);
      // S1 keeps rails up; S3, S4, S5 drop to standby only
      rails_ff <= (nxt_state == pwr_state_pkg::ST_S0) || (nxt_state == pwr_state_pkg::ST_S1);
      cpu_ff <= (nxt_state == pwr_state_pkg::ST_S0);
      cold_ff <= (state_ff == pwr_state_pkg::ST_S5) && (nxt_state == pwr_state_pkg::ST_S0);
      resume_ff <= in_sleep && (nxt_state == pwr_state_pkg::ST_S0);
    end
  end

  assign fan_on_o = fan_ff;
  assign main_rails_on_o = rails_ff;
  assign cpu_pwr_on_o = cpu_ff;
  assign cold_boot_o = cold_ff;
  assign resume_o = resume_ff;
  assign state_o = state_ff;

  // Assertions
  sequence s_leave_s5;
    state_ff == pwr_state_pkg::ST_S5 ##1 state_ff == pwr_state_pkg::ST_S0;
  endsequence
  sequence s_wake_up;
    in_sleep ##1 state_ff == pwr_state_pkg::ST_S0;
  endsequence

  // Soft-off itself ignores the long press; only on and sleep are forced off
  a_long_press_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (long_hit && state_ff != pwr_state_pkg::ST_S5) |=> state_ff == pwr_state_pkg::ST_S5)
    else $error("long press did not force soft-off");
  a_short_from_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S0 && short_press && !long_hit) |=>
      state_ff == pwr_state_pkg::ST_S1)
    else $error("short press from on did not sleep");
  a_short_from_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S5 && !boot_ff && short_press) |=>
      state_ff == pwr_state_pkg::ST_S0)
    else $error("short press from off did not power on");
  a_legacy_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S4 && !short_press && !wake_any && !wake_lanpme
      && wake_legacy) |=> state_ff != pwr_state_pkg::ST_S0)
    else $error("legacy wake accepted from S4");
  a_alarm_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S4 && alarm && !long_hit) |=>
      state_ff == pwr_state_pkg::ST_S0)
    else $error("alarm did not wake from S4");
  a_lan_s5_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S5 && !boot_ff && !lan_pme_s5_en_i && !wake_any
      && !short_press) |=> state_ff == pwr_state_pkg::ST_S5)
    else $error("S5 left without enabled source");
  // Outputs and state load on the same edge, so compare them directly
  a_fan_state: assert property (@(posedge clk_i) disable iff (rst_i)
    fan_on_o == (state_ff == pwr_state_pkg::ST_S0 || state_ff == pwr_state_pkg::ST_S1))
    else $error("fan output does not follow state");
  a_rails_s3: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S3) [*2] |-> !main_rails_on_o)
    else $error("rails up in S3");
  a_cold_boot: assert property (@(posedge clk_i) disable iff (rst_i)
    s_leave_s5 |-> cold_boot_o)
    else $error("no cold boot on leaving S5");
  a_cpu_s4: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S4) [*2] |-> !cpu_pwr_on_o && !fan_on_o)
    else $error("processor powered in S4");

  // Wake and command acceptance
  a_short_from_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && short_press && !long_hit) |=> state_ff == pwr_state_pkg::ST_S0)
    else $error("short press did not wake from sleep");
  a_legacy_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_ff == pwr_state_pkg::ST_S1 || state_ff == pwr_state_pkg::ST_S3) && wake_legacy
      && !long_hit) |=> state_ff == pwr_state_pkg::ST_S0)
    else $error("legacy wake refused from S1 or S3");
  a_lanpme_s4: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S4 && wake_lanpme && !long_hit) |=>
      state_ff == pwr_state_pkg::ST_S0)
    else $error("LAN or PME wake refused from S4");
  a_pme_s5_en: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S5 && !boot_ff && lan_pme_s5_en_i && wake_lanpme) |=>
      state_ff == pwr_state_pkg::ST_S0)
    else $error("enabled S5 wake refused");
  a_sleep_s3: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S0 && sleep_req_i && sleep_type_i == pwr_state_pkg::SLP_S3
      && !long_hit && !short_press) |=> state_ff == pwr_state_pkg::ST_S3 && !main_rails_on_o)
    else $error("S3 command did not drop rails");
  a_sleep_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_state_pkg::ST_S0 && sleep_req_i && sleep_type_i == pwr_state_pkg::SLP_S5
      && !short_press) |=> state_ff == pwr_state_pkg::ST_S5 && !main_rails_on_o)
    else $error("soft-off command did not drop rails");
  a_sleep_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff != pwr_state_pkg::ST_S0 && sleep_req_i && !boot_ff && !wake && !short_press
      && !long_hit) |=> $stable(state_ff))
    else $error("sleep command acted outside S0");
  a_no_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && !wake && !short_press && !long_hit) |=> $stable(state_ff))
    else $error("sleep left without a permitted event");

  // Output levels and pulses
  a_resume_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wake_up |-> resume_o)
    else $error("no resume pulse on wake");
  a_resume_only: assert property (@(posedge clk_i) disable iff (rst_i)
    resume_o |-> $past(in_sleep))
    else $error("resume pulse without sleep");
  a_cold_once: assert property (@(posedge clk_i) disable iff (rst_i)
    cold_boot_o |=> !cold_boot_o)
    else $error("cold boot pulse longer than one cycle");
  a_cold_only_s5: assert property (@(posedge clk_i) disable iff (rst_i)
    cold_boot_o |-> $past(state_ff) == pwr_state_pkg::ST_S5)
    else $error("cold boot pulse not from S5");
  a_rails_state: assert property (@(posedge clk_i) disable iff (rst_i)
    main_rails_on_o == (state_ff == pwr_state_pkg::ST_S0 || state_ff == pwr_state_pkg::ST_S1))
    else $error("rails do not follow state");
  a_cpu_state: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_pwr_on_o == (state_ff == pwr_state_pkg::ST_S0))
    else $error("processor power does not follow state");

  // Switch timing
  a_long_exact: assert property (@(posedge clk_i) disable iff (rst_i)
    long_hit |-> press_cnt_ff == LONG_PRESS_CYC - 1)
    else $error("long press not at the limit");
  a_debounce: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(sw_db_ff) |-> $past(db_cnt_ff) == DEBOUNCE_CYC - 1)
    else $error("switch changed before debounce");
endmodule

// file: tb/os_wake_model.sv
// Model of the switch, the wake sources and the OS sleep command.
// Assumes clk_i is shared with the controller; every drive follows a rising edge.
`timescale 1ns/10ps
module os_wake_model (
  input wire logic clk_i,
  output logic pwr_sw_n_o,
  output logic [6:0] wake_o,
  output logic sleep_req_o,
  output logic [1:0] sleep_type_o
);
  // Bits: rtc, pcie_n, ring, kbd, usb, lan, pme_n; active-low ones idle high
  initial begin
    pwr_sw_n_o = 1'b1;
    wake_o = 7'h42;
    sleep_req_o = 1'b0;
    sleep_type_o = 2'h0;
  end
  task automatic press(input int n);
    @(posedge clk_i) pwr_sw_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pwr_sw_n_o <= 1'b1;
  endtask
  // Held past the sync flops, then dropped so nothing stays pending
  task automatic wake(input int i);
    @(posedge clk_i) wake_o[i] <= ~wake_o[i];
    repeat (6) @(posedge clk_i);
    wake_o[i] <= ~wake_o[i];
  endtask
  task automatic sleep(input logic [1:0] t);
    @(posedge clk_i);
    sleep_req_o <= 1'b1;
    sleep_type_o <= t;
    @(posedge clk_i) sleep_req_o <= 1'b0;
  endtask
endmodule

// file: tb/board_power_state_controller_tb.sv
// Self-checking bench for the board power state controller.
// Assumes short test counts: long press 50 cycles, debounce 4.
`timescale 1ns/10ps
module board_power_state_controller_tb;
  logic clk_i, rst_i, pwr_sw_n, sleep_req, lan_en, restore_en, last_on;
  logic [6:0] wake;
  logic rtc_alarm, pcie_wake_n, ring, kbd_act, usb_act, lan_wake, pme_n;
  logic [1:0] sleep_type;
  logic fan_on, rails_on, cpu_on, cold_boot, resume;
  logic [4:0] state;
  int err_count = 0;
  int n_tests = 0;
  int n_cold = 0;
  int n_res = 0;
  assign {pme_n, lan_wake, usb_act, kbd_act, ring, pcie_wake_n, rtc_alarm} = wake;
  board_power_state_controller #(.LONG_PRESS_CYC(50), .DEBOUNCE_CYC(4)) u_board_power_state_controller (
    .clk_i(clk_i), .rst_i(rst_i), .pwr_sw_n_i(pwr_sw_n), .rtc_alarm_i(rtc_alarm),
    .pcie_wake_n_i(pcie_wake_n), .ring_i(ring), .kbd_act_i(kbd_act), .usb_act_i(usb_act),
    .lan_wake_i(lan_wake), .pme_n_i(pme_n), .lan_pme_s5_en_i(lan_en),
    .sleep_req_i(sleep_req), .sleep_type_i(sleep_type), .restore_en_i(restore_en),
    .last_on_i(last_on), .fan_on_o(fan_on), .main_rails_on_o(rails_on),
    .cpu_pwr_on_o(cpu_on), .cold_boot_o(cold_boot), .resume_o(resume), .state_o(state));
  os_wake_model u_os_wake_model (.clk_i(clk_i), .pwr_sw_n_o(pwr_sw_n), .wake_o(wake),
    .sleep_req_o(sleep_req), .sleep_type_o(sleep_type));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Pulses are one cycle wide, so count them as they pass
  always @(posedge clk_i) begin
    if (cold_boot === 1'b1) n_cold++;
    if (resume === 1'b1) n_res++;
  end
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_st(input logic [4:0] exp, input string msg);
    int k;
    k = 0;
    while (state !== exp && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    #1;
    check(state === exp, msg);
  endtask
  task automatic do_reset(input logic r, input logic l);
    @(posedge clk_i);
    rst_i <= 1'b1;
    restore_en <= r;
    last_on <= l;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic t_on_s3();
    int c;
    c = n_cold;
    do_reset(1'b0, 1'b0);
    // Restore is decided on the first edge after release, so look past it
    repeat (3) @(posedge clk_i);
    wait_st(5'h10, "no restore");
    u_os_wake_model.press(20);
    wait_st(5'h01, "short press from off");
    check(n_cold == c + 1 && fan_on === 1'b1, "cold boot, fans on");
    c = n_res;
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S3);
    wait_st(5'h04, "enter S3");
    check(fan_on === 1'b0 && rails_on === 1'b0, "S3 rails");
    u_os_wake_model.wake(2);
    wait_st(5'h01, "ring wake from S3");
    check(n_res == c + 1, "resume pulse");
    $display("test on_s3 done");
  endtask
  task automatic t_s4();
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S4);
    wait_st(5'h08, "enter S4");
    check(cpu_on === 1'b0 && rails_on === 1'b0 && fan_on === 1'b0, "S4 power");
    u_os_wake_model.wake(4);
    repeat (30) @(posedge clk_i);
    check(state === 5'h08, "usb ignored in S4");
    u_os_wake_model.wake(0);
    wait_st(5'h01, "alarm wake from S4");
    $display("test s4 done");
  endtask
  task automatic t_s5();
    int c;
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S5);
    wait_st(5'h10, "enter S5");
    u_os_wake_model.wake(5);
    repeat (30) @(posedge clk_i);
    check(state === 5'h10, "lan ignored in S5");
    lan_en <= 1'b1;
    c = n_cold;
    u_os_wake_model.wake(6);
    wait_st(5'h01, "pme wake from S5 enabled");
    check(n_cold == c + 1, "cold boot from S5");
    lan_en <= 1'b0;
    $display("test s5 done");
  endtask
  task automatic t_s1_long();
    u_os_wake_model.press(20);
    wait_st(5'h02, "short press to sleep");
    check(fan_on === 1'b1 && rails_on === 1'b1, "S1 fans");
    u_os_wake_model.wake(1);
    wait_st(5'h01, "express wake from S1");
    fork
      u_os_wake_model.press(90);
    join_none
    wait_st(5'h10, "long press forces off");
    check(fan_on === 1'b0, "fans off in S5");
    repeat (80) @(posedge clk_i);
    check(state === 5'h10, "release after long");
    $display("test s1_long done");
  endtask
  task automatic t_cmd();
    do_reset(1'b1, 1'b0);
    repeat (3) @(posedge clk_i);
    check(state === 5'h10, "restore keeps off when last state off");
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S1);
    repeat (3) @(posedge clk_i);
    check(state === 5'h10, "sleep command ignored in S5");
    u_os_wake_model.press(20);
    wait_st(5'h01, "short press from off again");
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S1);
    wait_st(5'h02, "enter S1 by command");
    check(fan_on === 1'b1 && rails_on === 1'b1 && cpu_on === 1'b0, "S1 power");
    u_os_wake_model.wake(3);
    wait_st(5'h01, "keyboard wake from S1");
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S4);
    wait_st(5'h08, "enter S4 again");
    u_os_wake_model.wake(5);
    wait_st(5'h01, "lan wake from S4");
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S3);
    wait_st(5'h04, "enter S3 again");
    u_os_wake_model.press(20);
    wait_st(5'h01, "short press wakes S3");
    u_os_wake_model.sleep(pwr_state_pkg::SLP_S3);
    wait_st(5'h04, "enter S3 for long press");
    u_os_wake_model.press(90);
    repeat (10) @(posedge clk_i);
    check(state === 5'h10, "long press from sleep");
    $display("test cmd done");
  endtask
  task automatic t_restore();
    do_reset(1'b1, 1'b1);
    wait_st(5'h01, "restore to on");
    $display("test restore done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    lan_en = 1'b0;
    restore_en = 1'b0;
    last_on = 1'b0;
    t_on_s3();
    t_s4();
    t_s5();
    t_s1_long();
    t_cmd();
    t_restore();
    wrap_up();
  end
  // Whole run is about 520 cycles
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule
